/* flic_pkg.sv */
// Constants for the four-level interrupt controller.
// Assumes a 32-bit Wishbone slave and registers in the low lane; flag 1 bit 8 and status bits 10:8 sit in lane 1.
package flic_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_EN_PRIM = 8'hA8;
   localparam logic [7:0] IDX_EN_TMR = 8'hE8;
   localparam logic [7:0] IDX_PRIO_LO0 = 8'hB8;
   localparam logic [7:0] IDX_PRIO_HI0 = 8'hB7;
   localparam logic [7:0] IDX_PRIO_LO1 = 8'hF8;
   localparam logic [7:0] IDX_PRIO_HI1 = 8'hF7;
   localparam logic [7:0] IDX_FLAG0 = 8'hC0;
   localparam logic [7:0] IDX_FLAG1 = 8'hC8;
   localparam logic [7:0] IDX_STAT = 8'hD0;

   localparam int NUM_SRC = 15;
   localparam int NUM_FLAG = 17;
   localparam int NUM_LVL = 4;
   localparam int GLOBAL_EN_BIT = 7;

   // Flag positions in the combined flag vector
   localparam int FLG_EXT0 = 0;
   localparam int FLG_T0 = 1;
   localparam int FLG_EXT1 = 2;
   localparam int FLG_T1 = 3;
   localparam int FLG_RX = 4;
   localparam int FLG_TX = 5;
   localparam int FLG_TW = 6;
   localparam int FLG_ADC = 7;
   localparam int FLG_CAP0 = 8;
   localparam int FLG_CMP0 = 12;
   localparam int FLG_BYTE_OV = 15;
   localparam int FLG_WORD_OV = 16;

   // Source indices, also the polling order (lower wins)
   localparam int SRC_ASYNC = 4;
   localparam int SRC_TW = 5;
   localparam int SRC_ADC = 6;
   localparam int SRC_CAP0 = 7;
   localparam int SRC_CMP0 = 11;
   localparam int SRC_TMR_OV = 14;
   localparam int SRC_HWCLR_LAST = 3;

   localparam logic [7:0] EN_RESET = 8'h00;
   localparam logic [7:0] PRIO_RESET = 8'h00;
   localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
endpackage

/* flic_top.sv */
// Four-level interrupt controller: flags, enables, priorities, nesting.
// Assumes a Wishbone master on clock_i and a core that pulses ack on
// vectoring and ret on return from a service routine.
// Operation
// - Fifteen sources, each any of four levels
// - Level is high bit then low bit
// - Forward only above every active level
// - Higher level preempts; lower resumes after return
// - Externals, timers, serial OR of receive/transmit
// - Timer gives capture, compare, overflow-OR requests
// - Capture flag set by its input event
// - Compare flag set on count equal value
// - Byte and word overflow set their flags
// - Capture, compare and overflow flags cleared only by software
// - Converter flag set when result ready
// - Converter flag: software clears, never sets
// - Two-wire flag set on status load
// - Software flag writes act like hardware, except that they cannot set the converter flag
// - Disabled source never reaches core
// - Global enable bit 7 gates everything
// - Primary enable register bit layout
// - Enable, low and high priority registers
// - Enable bit 1 enables, 0 disables
module flic_top #(
   parameter int ADDR_W = 10
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_request_pin_0_n_i,
   input wire logic ext_request_pin_1_n_i,
   input wire logic timer0_request_i,
   input wire logic timer1_request_i,
   input wire logic receive_flag_set_i,
   input wire logic transmit_flag_set_i,
   input wire logic twowire_status_load_i,
   input wire logic conversion_done_i,
   input wire logic [3:0] capture_input_i,
   input wire logic timer_tick_i,
   input wire logic [15:0] timer_count_i,
   input wire logic [15:0] compare_value_0_i,
   input wire logic [15:0] compare_value_1_i,
   input wire logic [15:0] compare_value_2_i,
   input wire logic irq_ack_i,
   input wire logic irq_ret_i,
   output logic irq_req_o,
   output logic [3:0] irq_vector_o,
   output logic [1:0] irq_level_o
);
   import flic_pkg::*;

   if (ADDR_W < 10) begin : g_chk
      $error("ADDR_W too small for the register map");
   end

   logic [7:0] en_prim_ff;
   logic [7:0] en_tmr_ff;
   logic [6:0] prio_lo0_ff;
   logic [6:0] prio_hi0_ff;
   logic [7:0] prio_lo1_ff;
   logic [7:0] prio_hi1_ff;
   logic [NUM_FLAG-1:0] flag_ff;
   logic [NUM_LVL-1:0] in_service_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic req_ff;
   logic [3:0] vec_ff;
   logic [1:0] lvl_ff;

   // Pin synchronisers; stage one feeds only stage two
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic [5:0] sync3_ff;

   logic bus_req;
   logic wr_en;
   logic [7:0] idx;
   logic [NUM_SRC-1:0] src_en;
   logic [NUM_SRC-1:0] prio_lo;
   logic [NUM_SRC-1:0] prio_hi;
   logic [NUM_SRC-1:0] src_req;
   logic [NUM_SRC-1:0] elig;
   logic [NUM_FLAG-1:0] hw_set;
   logic [NUM_FLAG-1:0] hw_clr;
   logic [NUM_FLAG-1:0] sw_we;
   logic [NUM_FLAG-1:0] sw_val;
   logic found;
   logic [3:0] best_idx;
   logic [1:0] best_lvl;
   logic allowed;
   logic [NUM_LVL-1:0] nxt_in_service;
   logic [31:0] nxt_dat;
   logic [1:0] cap_lvl;

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
   assign idx = wb_adr_i[9:2];

   // Source enables and priorities in polling order
   assign src_en = {en_tmr_ff, en_prim_ff[6:0]};
   assign prio_lo = {prio_lo1_ff, prio_lo0_ff};
   assign prio_hi = {prio_hi1_ff, prio_hi0_ff};

   // Flag to source mapping
   assign src_req[3:0] = flag_ff[FLG_T1:FLG_EXT0];
   assign src_req[SRC_ASYNC] = flag_ff[FLG_RX] | flag_ff[FLG_TX];
   assign src_req[SRC_TW] = flag_ff[FLG_TW];
   assign src_req[SRC_ADC] = flag_ff[FLG_ADC];
   assign src_req[SRC_CMP0-1:SRC_CAP0] = flag_ff[FLG_CAP0+3:FLG_CAP0];
   assign src_req[SRC_TMR_OV-1:SRC_CMP0] = flag_ff[FLG_CMP0+2:FLG_CMP0];
   assign src_req[SRC_TMR_OV] =
      flag_ff[FLG_BYTE_OV] | flag_ff[FLG_WORD_OV];

   // Enable bit 1 passes, global bit gates all
   assign elig = src_req & src_en &
      {NUM_SRC{en_prim_ff[GLOBAL_EN_BIT]}};

   // Highest level wins; descending scan lets the lower index win ties
   always_comb begin
      found = 1'b0;
      best_idx = 4'h0;
      best_lvl = 2'h0;
      cap_lvl = 2'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         cap_lvl = {prio_hi[i], prio_lo[i]};
         if (elig[i] && (!found || cap_lvl >= best_lvl)) begin
            found = 1'b1;
            best_idx = 4'(i);
            best_lvl = cap_lvl;
         end
      end
   end

   // Nothing equal or above may already be in service
   assign allowed = found && ((in_service_ff >> best_lvl) == 4'h0);

   // Pin synchronisers
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sync1_ff <= 6'h3F;
         sync2_ff <= 6'h3F;
         sync3_ff <= 6'h3F;
      end else begin
         sync1_ff <= {capture_input_i, ext_request_pin_1_n_i,
                      ext_request_pin_0_n_i};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // Hardware set and clear events
   always_comb begin
      hw_set = '0;
      hw_clr = '0;
      hw_set[FLG_EXT0] = sync3_ff[0] && !sync2_ff[0];
      hw_set[FLG_EXT1] = sync3_ff[1] && !sync2_ff[1];
      hw_set[FLG_T0] = timer0_request_i;
      hw_set[FLG_T1] = timer1_request_i;
      hw_set[FLG_RX] = receive_flag_set_i;
      hw_set[FLG_TX] = transmit_flag_set_i;
      hw_set[FLG_TW] = twowire_status_load_i;
      hw_set[FLG_ADC] = conversion_done_i;
      for (int c = 0; c < 4; c++) begin
         hw_set[FLG_CAP0+c] = !sync3_ff[2+c] && sync2_ff[2+c];
      end
      hw_set[FLG_CMP0] = timer_tick_i &&
         (timer_count_i == compare_value_0_i);
      hw_set[FLG_CMP0+1] = timer_tick_i &&
         (timer_count_i == compare_value_1_i);
      hw_set[FLG_CMP0+2] = timer_tick_i &&
         (timer_count_i == compare_value_2_i);
      hw_set[FLG_BYTE_OV] = timer_tick_i &&
         (timer_count_i[7:0] == BYTE_ALL_ONES);
      hw_set[FLG_WORD_OV] = timer_tick_i &&
         (timer_count_i == CNT_ALL_ONES);
      // Vectoring clears only external and timer 0/1 flags
      if (irq_ack_i && req_ff && vec_ff <= 4'(SRC_HWCLR_LAST)) begin
         hw_clr[vec_ff] = 1'b1;
      end
   end

   // Software flag writes
   always_comb begin
      sw_we = '0;
      sw_val = '0;
      if (wr_en && idx == IDX_FLAG0) begin
         sw_we[7:0] = 8'hFF;
         sw_val[7:0] = wb_dat_i[7:0];
      end
      if (bus_req && wb_we_i && idx == IDX_FLAG1) begin
         sw_we[15:8] = {8{wb_sel_i[0]}};
         sw_val[15:8] = wb_dat_i[7:0];
         sw_we[16] = wb_sel_i[1];
         sw_val[16] = wb_dat_i[8];
      end
   end

   // One flop per flag; a hardware set wins over any clear
   for (genvar f = 0; f < NUM_FLAG; f++) begin : g_flag
      always_ff @(posedge clock_i) begin
         if (rst_i) begin
            flag_ff[f] <= 1'b0;
         end else if (hw_set[f]) begin
            flag_ff[f] <= 1'b1;
         end else if (sw_we[f]) begin
            if (f == FLG_ADC) begin
               flag_ff[f] <= flag_ff[f] & sw_val[f];
            end else begin
               flag_ff[f] <= sw_val[f];
            end
         end else if (hw_clr[f]) begin
            flag_ff[f] <= 1'b0;
         end
      end
   end

   // Enable and priority registers, all zero after reset
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         en_prim_ff <= EN_RESET;
         en_tmr_ff <= EN_RESET;
         prio_lo0_ff <= PRIO_RESET[6:0];
         prio_hi0_ff <= PRIO_RESET[6:0];
         prio_lo1_ff <= PRIO_RESET;
         prio_hi1_ff <= PRIO_RESET;
      end else if (wr_en) begin
         unique case (idx)
            IDX_EN_PRIM: en_prim_ff <= wb_dat_i[7:0];
            IDX_EN_TMR: en_tmr_ff <= wb_dat_i[7:0];
            IDX_PRIO_LO0: prio_lo0_ff <= wb_dat_i[6:0];
            IDX_PRIO_HI0: prio_hi0_ff <= wb_dat_i[6:0];
            IDX_PRIO_LO1: prio_lo1_ff <= wb_dat_i[7:0];
            IDX_PRIO_HI1: prio_hi1_ff <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   // Nesting: ack marks a level active, return retires the top one
   always_comb begin
      nxt_in_service = in_service_ff;
      if (irq_ret_i) begin
         if (in_service_ff[3]) begin
            nxt_in_service[3] = 1'b0;
         end else if (in_service_ff[2]) begin
            nxt_in_service[2] = 1'b0;
         end else if (in_service_ff[1]) begin
            nxt_in_service[1] = 1'b0;
         end else begin
            nxt_in_service[0] = 1'b0;
         end
      end
      if (irq_ack_i && req_ff) begin
         nxt_in_service[lvl_ff] = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         in_service_ff <= 4'h0;
      end else begin
         in_service_ff <= nxt_in_service;
      end
   end

   // Request to core; dropped after ack until service state settles
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         req_ff <= 1'b0;
         vec_ff <= 4'h0;
         lvl_ff <= 2'h0;
      end else begin
         req_ff <= allowed && !irq_ack_i && !irq_ret_i;
         vec_ff <= best_idx;
         lvl_ff <= best_lvl;
      end
   end

   assign irq_req_o = req_ff;
   assign irq_vector_o = vec_ff;
   assign irq_level_o = lvl_ff;

   // Read mux; unmapped indices read zero
   always_comb begin
      nxt_dat = 32'h0000_0000;
      unique case (idx)
         IDX_EN_PRIM: nxt_dat[7:0] = en_prim_ff;
         IDX_EN_TMR: nxt_dat[7:0] = en_tmr_ff;
         IDX_PRIO_LO0: nxt_dat[6:0] = prio_lo0_ff;
         IDX_PRIO_HI0: nxt_dat[6:0] = prio_hi0_ff;
         IDX_PRIO_LO1: nxt_dat[7:0] = prio_lo1_ff;
         IDX_PRIO_HI1: nxt_dat[7:0] = prio_hi1_ff;
         IDX_FLAG0: nxt_dat[7:0] = flag_ff[7:0];
         IDX_FLAG1: nxt_dat[8:0] = flag_ff[16:8];
         IDX_STAT: nxt_dat[10:0] = {lvl_ff, vec_ff, req_ff, in_service_ff};
         default: ;
      endcase
   end

   // Single wait-free answer, one cycle after the strobe
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= bus_req;
         dat_ff <= (bus_req && !wb_we_i) ? nxt_dat : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   // Checks
   a_level_encoding: assert property (
      @(posedge clock_i) disable iff (rst_i)
      irq_req_o |-> irq_level_o ==
         {$past(prio_hi[best_idx]), $past(prio_lo[best_idx])})
      else $error("request level does not match priority bits");

   a_no_equal_nest: assert property (
      @(posedge clock_i) disable iff (rst_i)
      irq_req_o |-> ($past(in_service_ff) >> irq_level_o) == 4'h0)
      else $error("request raised over an equal or higher level");

   a_ack_marks_level: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (irq_ack_i && irq_req_o && !irq_ret_i) |=>
         in_service_ff[$past(irq_level_o)] && !irq_req_o)
      else $error("ack did not mark the level in service");

   a_capture_sets: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (!sync3_ff[2] && sync2_ff[2]) |=> flag_ff[FLG_CAP0])
      else $error("capture event did not set its flag");

   a_timer_flag_holds: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (flag_ff[FLG_WORD_OV] && !sw_we[FLG_WORD_OV]) |=> flag_ff[FLG_WORD_OV])
      else $error("timer overflow flag cleared without software");

   a_adc_no_sw_set: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (!flag_ff[FLG_ADC] && !conversion_done_i && wr_en &&
       idx == IDX_FLAG0 && wb_dat_i[FLG_ADC]) |=> !flag_ff[FLG_ADC])
      else $error("software write set the converter flag");

   a_enable_gates: assert property (
      @(posedge clock_i) disable iff (rst_i)
      irq_req_o |-> $past(src_en[best_idx]) &&
         $past(src_req[best_idx]))
      else $error("disabled or idle source forwarded");

   a_global_gate: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !en_prim_ff[GLOBAL_EN_BIT] |=> !irq_req_o)
      else $error("request passed with global enable clear");

   a_bus_ack_pulse: assert property (
      @(posedge clock_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held longer than one cycle");
endmodule

/* flic_core_model.sv */
// Core model: vectors on a request and returns from a routine on command.
// Assumes the controller's request, vector and level are registered.
module flic_core_model (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic slow_i,
   input wire logic ret_go_i,
   input wire logic irq_req_i,
   input wire logic [3:0] irq_vector_i,
   input wire logic [1:0] irq_level_i,
   output logic irq_ack_o,
   output logic irq_ret_o,
   output logic taken_o,
   output logic [5:0] taken_id_o
);
   logic [1:0] wait_ff;
   always_ff @(posedge clock_i) begin
      if (rst_i || !irq_req_i || irq_ack_o) begin
         wait_ff <= 2'h0;
      end else begin
         wait_ff <= wait_ff + 2'h1;
      end
   end
   // Single ack pulse; a request that drops meanwhile is not taken
   always_ff @(posedge clock_i) begin
      irq_ack_o <= !rst_i && run_i && irq_req_i && !irq_ack_o
         && wait_ff == (slow_i ? 2'h3 : 2'h0);
      irq_ret_o <= !rst_i && ret_go_i;
      taken_o <= !rst_i && irq_ack_o && irq_req_i;
      taken_id_o <= {irq_level_i, irq_vector_i};
   end
endmodule

/* tb.sv */
// Bench for the four-level interrupt controller with a core model.
// Assumes flic_pkg, flic_top and flic_core_model compiled before it.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flic_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic run = 1'b1, slow = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic [7:0] pls = 8'h00;
   logic [3:0] cap = 4'h0;
   logic [1:0] ext_n = 2'h3;
   logic [15:0] cnt = 16'h0, cmp0 = 16'h0, cmp1 = 16'h0, cmp2 = 16'h1;
   logic [3:0] sel = 4'hf;
   logic [31:0] seed = 32'hc517_d922;
   logic [31:0] rdat, r;
   logic ack, req, iack, iret, taken;
   logic [3:0] vec;
   logic [1:0] lvl;
   logic [5:0] tid;
   int error_cnt = 0;
   int checked = 0;
   logic [31:0] rd_q[$];
   logic [5:0] id_q[$];
   logic [7:0] regs[7] = '{IDX_EN_PRIM, IDX_EN_TMR, IDX_PRIO_LO0,
      IDX_PRIO_HI0, IDX_PRIO_LO1, IDX_PRIO_HI1, 8'h10};
   logic [5:0] hw_id[5] = '{6'h01, 6'h03, 6'h04, 6'h04, 6'h05};

   initial forever #4 clk = ~clk;

   flic_top u_dut (
      .clock_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack),
      .ext_request_pin_0_n_i(ext_n[0]), .ext_request_pin_1_n_i(ext_n[1]),
      .timer0_request_i(pls[0]), .timer1_request_i(pls[1]),
      .receive_flag_set_i(pls[2]), .transmit_flag_set_i(pls[3]),
      .twowire_status_load_i(pls[4]), .conversion_done_i(pls[5]),
      .capture_input_i(cap), .timer_tick_i(pls[6]), .timer_count_i(cnt),
      .compare_value_0_i(cmp0), .compare_value_1_i(cmp1),
      .compare_value_2_i(cmp2), .irq_ack_i(iack),
      .irq_ret_i(iret), .irq_req_o(req), .irq_vector_o(vec),
      .irq_level_o(lvl)
   );

   flic_core_model u_core (
      .clock_i(clk), .rst_i(rst), .run_i(run), .slow_i(slow),
      .ret_go_i(pls[7]), .irq_req_i(req), .irq_vector_i(vec),
      .irq_level_i(lvl), .irq_ack_o(iack), .irq_ret_o(iret),
      .taken_o(taken), .taken_id_o(tid)
   );

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic results();
      $display("mismatches %0d of %0d checks", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] idx,
         input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= d;
      // Held until ack is seen high at a rising edge; watchdog ends a hang
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      wb(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, idx, 32'h0);
   endtask

   task automatic pulse(input int b);
      @(posedge clk);
      pls[b] <= 1'b1;
      @(posedge clk);
      pls <= 8'h00;
   endtask

   // Waits for every noted vectoring to be seen by the watcher
   task automatic drain();
      int n = 0;
      while (id_q.size() > 0 && n < 60) begin
         @(posedge clk);
         n++;
      end
      check(32'(id_q.size()), 32'h0);
      repeat (2) @(posedge clk);
   endtask

   task automatic take(input logic [5:0] id, input logic [31:0] d);
      id_q.push_back(id);
      wr(IDX_FLAG0, d);
      drain();
   endtask

   // Any vectoring not noted in advance is a mismatch
   always @(negedge clk) begin
      if (ack === 1'b1 && we === 1'b0)
         check(rdat, rd_q.size() > 0 ? rd_q.pop_front() : 32'hdead_beef);
      if (taken === 1'b1)
         check({26'h0, tid}, id_q.size() > 0 ?
            {26'h0, id_q.pop_front()} : 32'h40);
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      results();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (regs[i]) rd(regs[i], 32'h0);
      r = xs();
      wr(IDX_PRIO_LO0, r);
      rd(IDX_PRIO_LO0, {25'h0, r[6:0]});
      wr(8'h10, r);
      rd(8'h10, 32'h0);
      wr(IDX_PRIO_LO0, 32'h0);
      wr(IDX_EN_TMR, 32'hff);
      rd(IDX_EN_TMR, 32'hff);
      // Lane 0 disabled: the write must be ignored
      sel <= 4'he;
      wr(IDX_EN_TMR, 32'h0);
      sel <= 4'hf;
      rd(IDX_EN_TMR, 32'hff);
      wr(IDX_EN_PRIM, 32'hff);
      for (int s = 0; s < NUM_SRC; s++) begin
         id_q.push_back(6'(s));
         if (s == SRC_ADC) pulse(5);
         else if (s < SRC_ADC) wr(IDX_FLAG0, 32'h1 << ((s < 5) ? s : 6));
         else wr(IDX_FLAG1, 32'h1 << (s - SRC_CAP0));
         drain();
         wr(IDX_FLAG0, 32'h0);
         wr(IDX_FLAG1, 32'h0);
         pulse(7);
      end
      wr(IDX_FLAG0, 32'h80);
      rd(IDX_FLAG0, 32'h0);
      wr(IDX_EN_PRIM, 32'h7f);
      wr(IDX_FLAG0, 32'h2);
      repeat (12) @(posedge clk);
      wr(IDX_EN_PRIM, 32'h80);
      repeat (12) @(posedge clk);
      id_q.push_back(6'h01);
      wr(IDX_EN_PRIM, 32'h82);
      drain();
      pulse(7);
      wr(IDX_PRIO_LO0, 32'h07);
      wr(IDX_PRIO_HI0, 32'h0e);
      wr(IDX_EN_PRIM, 32'h8f);
      slow <= 1'b1;
      take(6'h10, 32'h1);
      take(6'h23, 32'h8);
      take(6'h31, 32'h2);
      wr(IDX_FLAG0, 32'h4);
      repeat (12) @(posedge clk);
      id_q.push_back(6'h32);
      pulse(7);
      drain();
      repeat (3) pulse(7);
      wr(IDX_PRIO_LO0, 32'h0);
      wr(IDX_PRIO_HI0, 32'h0);
      wr(IDX_EN_PRIM, 32'hff);
      // Both pending before the core may answer, so the tie is real
      run <= 1'b0;
      wr(IDX_FLAG0, 32'h50);
      repeat (4) @(posedge clk);
      id_q.push_back(6'h04);
      run <= 1'b1;
      drain();
      wr(IDX_FLAG0, 32'h40);
      id_q.push_back(6'h05);
      pulse(7);
      drain();
      wr(IDX_FLAG0, 32'h0);
      pulse(7);
      foreach (hw_id[i]) begin
         id_q.push_back(hw_id[i]);
         pulse(i);
         drain();
         wr(IDX_FLAG0, 32'h0);
         pulse(7);
      end
      r = xs();
      cmp0 <= (r[15:0] & 16'hff7f) | 16'h0100;
      cnt <= (r[15:0] & 16'hff7f) | 16'h0100;
      id_q.push_back(6'(SRC_CMP0));
      pulse(6);
      drain();
      rd(IDX_FLAG1, 32'h10);
      wr(IDX_FLAG1, 32'h0);
      pulse(7);
      cnt <= 16'hffff;
      id_q.push_back(6'(SRC_TMR_OV));
      pulse(6);
      drain();
      rd(IDX_FLAG1, 32'h180);
      wr(IDX_FLAG1, 32'h0);
      pulse(7);
      cmp1 <= 16'h2a5b;
      cnt <= 16'h2a5b;
      id_q.push_back(6'h0c);
      pulse(6);
      drain();
      rd(IDX_FLAG1, 32'h20);
      wr(IDX_FLAG1, 32'h0);
      pulse(7);
      // Compare 2 and both overflows in one tick; lowest index served
      cnt <= 16'hffff;
      cmp2 <= 16'hffff;
      id_q.push_back(6'h0d);
      pulse(6);
      drain();
      rd(IDX_FLAG1, 32'h1c0);
      wr(IDX_FLAG1, 32'h0);
      pulse(7);
      id_q.push_back(6'h09);
      cap <= 4'h4;
      drain();
      rd(IDX_FLAG1, 32'h4);
      wr(IDX_FLAG1, 32'h0);
      pulse(7);
      id_q.push_back(6'h00);
      ext_n <= 2'h2;
      drain();
      pulse(7);
      repeat (4) @(posedge clk);
      check(32'(id_q.size() + rd_q.size()), 32'h0);
      results();
   end
endmodule
